// file: rtl/dtfe_pkg.sv
package dtfe_pkg;
  typedef enum logic [2:0] {
    DTFE_SRC_INT,
    DTFE_SRC_EXT_RISE,
    DTFE_SRC_EXT_FALL,
    DTFE_SRC_ARM_RISE,
    DTFE_SRC_ARM_FALL,
    DTFE_SRC_MANUAL,
    DTFE_SRC_LINE
  } dtfe_src_e;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RATE_W = 48;
  // Phase accumulator: one increment LSB = 100 MHz / 2^48, about 0.36 uHz
  localparam logic [RATE_W-1:0] RATE_RST = 48'h0000_0000_03e8;
  localparam int unsigned TRIG_PRE_W = 30;
  localparam int unsigned OUT_PRE_W = 16;
  localparam int unsigned HOLD_W = 32;
  localparam int unsigned LATENCY_NS = 85;
  localparam int unsigned LATENCY_CYC =
    (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_TAIL_NS = 25;
  localparam int unsigned REF_TAIL_CYC =
    (REF_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TRIG_PRE_W-1:0] TRIG_PRE_RST = 30'h0000_0001;
  localparam logic [OUT_PRE_W-1:0] OUT_PRE_RST = 16'h0001;
  localparam logic [OUT_PRE_W-1:0] OUT_PHASE_RST = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_RST = 32'h0000_0000;
endpackage

// file: rtl/dtfe_pre_if.sv
`timescale 1ns/1ns
interface dtfe_pre_if;
  logic clear;
  logic cycle_start;
  logic bypass;
  logic [15:0] modulus;
  logic [15:0] phase;
  logic enable;
  modport top (output clear, output cycle_start, output bypass,
    output modulus, output phase, input enable);
  modport pre (input clear, input cycle_start, input bypass,
    input modulus, input phase, output enable);
endinterface

// file: rtl/dtfe_out_prescaler.sv
`timescale 1ns/1ns
module dtfe_out_prescaler (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  dtfe_pre_if.pre p
);
  logic [15:0] count;

  // Count delay cycles within the group of M
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= dtfe_pkg::OUT_PHASE_RST;
    end else if (p.clear) begin
      count <= dtfe_pkg::OUT_PHASE_RST;
    end else if (p.cycle_start && !p.bypass) begin
      if (count + 16'h0001 >= p.modulus) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // Enable is latched at cycle start and held for the cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      p.enable <= 1'b0;
    end else if (p.cycle_start) begin
      p.enable <= p.bypass || (count == p.phase);
    end
  end
endmodule

// file: rtl/dtfe_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Seven trigger sources chosen by the source select input.
// - Internal rate from 100 uHz to 10 MHz, about 0.36 uHz resolution.
// - New internal rate takes effect at once, no settling.
// - External edges of chosen polarity accepted up to 10 MHz.
// - Fixed latency from external edge to reference output.
// - Each accepted manual one-shot command gives exactly one delay cycle.
// - Arm accepts exactly one later edge; others ignored until rearmed.
// - Armed-ready shown from arm until that edge is accepted.
// - Line mode gives one trigger per mains cycle.
// - Guard time and prescalers act only with advanced enable set.
// - Advanced mode ignores triggers before guard time has elapsed, except in single-shot modes.
// - Each guard-time discard pulses the overrun indicator once.
// - Trigger prescaler starts one cycle every N accepted triggers.
// - Each output prescaler enables one of every M delay cycles.
// - Output phase picks which cycle in the group is enabled.
// - Single-shot modes bypass all prescalers; all outputs enabled.
// - Cycle-active set when a trigger starts a cycle, cleared when delays done.
// - Trigger during a delay in progress is discarded, pulses overrun.
// - Triggers while blocked or settings change are discarded, flagged.
// - Burst-active flag follows burst enable.
// - Reference pulse ends at later of guard time (not in single-shot modes) or delays done+25ns.
module dtfe_top #(
  parameter int unsigned NUM_OUT = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire dtfe_pkg::dtfe_src_e trig_source_in,
  input wire logic [dtfe_pkg::RATE_W-1:0] rate_step_in,
  input wire logic ext_trig_in,
  input wire logic line_in,
  input wire logic one_shot_cmd_in,
  input wire logic advanced_enable_in,
  input wire logic [dtfe_pkg::HOLD_W-1:0] guard_cycles_in,
  input wire logic [dtfe_pkg::TRIG_PRE_W-1:0] trig_prescale_in,
  input wire logic [NUM_OUT*16-1:0] out_prescale_in,
  input wire logic [NUM_OUT*16-1:0] out_phase_in,
  input wire logic prescale_write_in,
  input wire logic inhibit_in,
  input wire logic settings_busy_in,
  input wire logic burst_enable_in,
  input wire logic delays_done_in,
  output logic delay_start_out,
  output logic [NUM_OUT-1:0] out_enable_out,
  output logic reference_output,
  output logic cycle_active_out,
  output logic armed_ready_out,
  output logic overrun_out,
  output logic blocked_trigger_flag,
  output logic burst_active_out
);
  localparam int unsigned LAT = dtfe_pkg::LATENCY_CYC;

  logic ext_meta, ext_sync, ext_prev;
  logic line_meta, line_sync, line_prev;
  logic inh_meta, inh_sync;
  logic [dtfe_pkg::RATE_W-1:0] phase_acc;
  logic int_tick;
  logic ext_rise, ext_fall, line_rise;
  logic raw_trig;
  logic one_shot_mode;
  logic armed;
  dtfe_pkg::dtfe_src_e src_prev;
  logic src_change;
  logic [dtfe_pkg::HOLD_W-1:0] guard_cnt;
  logic guard_busy;
  logic [dtfe_pkg::TRIG_PRE_W-1:0] trig_cnt;
  logic accept;
  logic start_now;
  logic [LAT-1:0] start_pipe;
  logic [7:0] tail_cnt;
  logic delays_seen;
  logic clear_cnt;
  logic [NUM_OUT-1:0] pre_en;

  // Pins outside the clock domain get two flip-flops
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      line_meta <= 1'b0;
      line_sync <= 1'b0;
      line_prev <= 1'b0;
      inh_meta <= 1'b0;
      inh_sync <= 1'b0;
    end else begin
      ext_meta <= ext_trig_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      line_meta <= line_in;
      line_sync <= line_meta;
      line_prev <= line_sync;
      inh_meta <= inhibit_in;
      inh_sync <= inh_meta;
    end
  end

  assign ext_rise = ext_sync && !ext_prev;
  assign ext_fall = !ext_sync && ext_prev;
  assign line_rise = line_sync && !line_prev;

  // Phase accumulator; carry out is the internal trigger.
  // Step is read every cycle, so a new rate acts immediately.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_acc <= '0;
      int_tick <= 1'b0;
    end else begin
      {int_tick, phase_acc} <= {1'b0, phase_acc} +
        {1'b0, rate_step_in};
    end
  end

  assign one_shot_mode = (trig_source_in == dtfe_pkg::DTFE_SRC_ARM_RISE) ||
    (trig_source_in == dtfe_pkg::DTFE_SRC_ARM_FALL) ||
    (trig_source_in == dtfe_pkg::DTFE_SRC_MANUAL);

  // Source multiplexer
  always_comb begin
    unique case (trig_source_in)
      dtfe_pkg::DTFE_SRC_INT: raw_trig = int_tick;
      dtfe_pkg::DTFE_SRC_EXT_RISE: raw_trig = ext_rise;
      dtfe_pkg::DTFE_SRC_EXT_FALL: raw_trig = ext_fall;
      dtfe_pkg::DTFE_SRC_ARM_RISE: raw_trig = ext_rise && armed;
      dtfe_pkg::DTFE_SRC_ARM_FALL: raw_trig = ext_fall && armed;
      dtfe_pkg::DTFE_SRC_MANUAL: raw_trig = one_shot_cmd_in;
      dtfe_pkg::DTFE_SRC_LINE: raw_trig = line_rise;
      default: raw_trig = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_prev <= dtfe_pkg::DTFE_SRC_INT;
    end else begin
      src_prev <= trig_source_in;
    end
  end
  assign src_change = src_prev != trig_source_in;
  assign clear_cnt = src_change || prescale_write_in;

  assign guard_busy = advanced_enable_in && !one_shot_mode &&
    (guard_cnt != '0);

  // Priority: blocked, then busy, then guard time
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      blocked_trigger_flag <= 1'b0;
    end else begin
      blocked_trigger_flag <= raw_trig &&
        (inh_sync || settings_busy_in);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_out <= 1'b0;
    end else begin
      overrun_out <= raw_trig && !inh_sync && !settings_busy_in &&
        (cycle_active_out || guard_busy);
    end
  end
  assign accept = raw_trig && !inh_sync && !settings_busy_in &&
    !cycle_active_out && !guard_busy;

  // Arm stays until one edge is accepted or the source changes; a new arm wins
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed <= 1'b0;
    end else if (src_change) begin
      armed <= 1'b0;
    end else if (one_shot_cmd_in && (trig_source_in ==
        dtfe_pkg::DTFE_SRC_ARM_RISE || trig_source_in ==
        dtfe_pkg::DTFE_SRC_ARM_FALL)) begin
      armed <= 1'b1;
    end else if (accept) begin
      armed <= 1'b0;
    end
  end
  assign armed_ready_out = armed;

  // Guard time counts from each accepted trigger
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      guard_cnt <= dtfe_pkg::HOLD_RST;
    end else if (accept) begin
      guard_cnt <= guard_cycles_in;
    end else if (guard_cnt != '0) begin
      guard_cnt <= guard_cnt - 1'b1;
    end
  end

  // Trigger prescaler
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_cnt <= '0;
    end else if (clear_cnt) begin
      trig_cnt <= '0;
    end else if (accept && advanced_enable_in && !one_shot_mode) begin
      if (trig_cnt + 1'b1 >= trig_prescale_in) begin
        trig_cnt <= '0;
      end else begin
        trig_cnt <= trig_cnt + 1'b1;
      end
    end
  end
  assign start_now = accept && (one_shot_mode || !advanced_enable_in ||
    (trig_cnt + 1'b1 >= trig_prescale_in));

  // Fixed pipeline gives the constant insertion delay
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_pipe <= '0;
    end else begin
      start_pipe <= {start_pipe[LAT-2:0], start_now};
    end
  end
  assign delay_start_out = start_pipe[LAT-1];

  // Active from cycle start until delays finish
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cycle_active_out <= 1'b0;
    end else if (start_now) begin
      cycle_active_out <= 1'b1;
    end else if (cycle_active_out && delays_seen) begin
      cycle_active_out <= 1'b0;
    end
  end

  // Delays_done only counts after the start has reached the engine
  // Kept until the next start so the reference tail can end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      delays_seen <= 1'b0;
    end else if (start_now || start_pipe != '0) begin
      delays_seen <= 1'b0;
    end else if (cycle_active_out && delays_done_in) begin
      delays_seen <= 1'b1;
    end
  end

  // Tail counter runs only once the delays have finished
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tail_cnt <= '0;
    end else if (start_pipe[LAT-2]) begin
      tail_cnt <= 8'(dtfe_pkg::REF_TAIL_CYC);
    end else if (reference_output && delays_seen && tail_cnt != '0) begin
      tail_cnt <= tail_cnt - 8'h01;
    end
  end

  // Reference pulse: tail after delays, also held by guard time
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reference_output <= 1'b0;
    end else if (start_pipe[LAT-2]) begin
      reference_output <= 1'b1;
    end else if (reference_output) begin
      // Guard holds the pulse only where it also holds triggers
      if (delays_seen && tail_cnt <= 8'h01 && !guard_busy) begin
        reference_output <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      burst_active_out <= 1'b0;
    end else begin
      burst_active_out <= burst_enable_in;
    end
  end

  // One prescaler per output; enable aligned to delayed start
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    dtfe_pre_if pif ();
    assign pif.clear = clear_cnt;
    assign pif.cycle_start = start_now;
    assign pif.bypass = one_shot_mode || !advanced_enable_in;
    assign pif.modulus = out_prescale_in[i*16 +: 16];
    assign pif.phase = out_phase_in[i*16 +: 16];
    assign pre_en[i] = pif.enable;
    dtfe_out_prescaler u_pre (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .p(pif.pre)
    );
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_enable_out <= '0;
    end else if (start_pipe[LAT-2]) begin
      out_enable_out <= pre_en;
    end
  end
endmodule

// file: tb/dtfe_chk.sv
`timescale 1ns/1ns
module dtfe_chk #(
  parameter int unsigned NUM_OUT = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire dtfe_pkg::dtfe_src_e trig_source_in,
  input wire logic one_shot_cmd_in,
  input wire logic advanced_enable_in,
  input wire logic inhibit_in,
  input wire logic settings_busy_in,
  input wire logic burst_enable_in,
  input wire logic delays_done_in,
  input wire logic delay_start_out,
  input wire logic [NUM_OUT-1:0] out_enable_out,
  input wire logic reference_output,
  input wire logic cycle_active_out,
  input wire logic armed_ready_out,
  input wire logic overrun_out,
  input wire logic blocked_trigger_flag,
  input wire logic burst_active_out
);
  logic [2:0] inh_d;
  logic man, arm, ok;
  // Inhibit crosses a 2 FF sync, so wait out its history
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) inh_d <= 3'h0;
    else inh_d <= {inh_d[1:0], inhibit_in};
  end
  assign man = trig_source_in == dtfe_pkg::DTFE_SRC_MANUAL;
  assign arm = trig_source_in inside {dtfe_pkg::DTFE_SRC_ARM_RISE,
    dtfe_pkg::DTFE_SRC_ARM_FALL};
  assign ok = !inhibit_in && inh_d == 3'h0 && !settings_busy_in;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_burst_follow: assert property (!$past(rst_in) |->
    burst_active_out == $past(burst_enable_in)) else $error("burst flag");
  a_manual_cycle: assert property (man && one_shot_cmd_in && ok &&
    !cycle_active_out |=> cycle_active_out ##8
    (delay_start_out && (&out_enable_out))) else $error("manual shot");
  a_ref_rise: assert property ($rose(reference_output) |->
    delay_start_out) else $error("reference start");
  a_ref_tail: assert property ($fell(reference_output) |->
    !$past(cycle_active_out, 2)) else $error("reference tail");
  a_active_fall: assert property ($fell(cycle_active_out) |->
    $past(delays_done_in) || $past(delays_done_in, 2)) else $error("active");
  a_overrun_busy: assert property (man && one_shot_cmd_in && ok &&
    cycle_active_out |=> overrun_out && !blocked_trigger_flag)
    else $error("overrun");
  a_blocked_shot: assert property (man && one_shot_cmd_in &&
    settings_busy_in |=> blocked_trigger_flag && !$rose(cycle_active_out))
    else $error("blocked");
  a_arm_rise: assert property ($rose(armed_ready_out) |->
    $past(one_shot_cmd_in)) else $error("armed flag");
  a_arm_only: assert property (arm && $stable(trig_source_in) &&
    $rose(cycle_active_out) |-> $past(armed_ready_out)) else $error("arm");
  a_outs_all: assert property (delay_start_out &&
    (!advanced_enable_in || man || arm) |-> &out_enable_out)
    else $error("bypass");
  c_overrun: cover property (overrun_out);
  c_blocked: cover property (blocked_trigger_flag);
  c_armed: cover property ($fell(armed_ready_out));
endmodule

// file: tb/dtfe_partner.sv
`timescale 1ns/1ns
module dtfe_partner (
  input wire logic sys_clk_in,
  input wire logic delay_start_in,
  output logic ext_trig_out = 1'b0,
  output logic line_out = 1'b0,
  output logic done_out = 1'b0
);
  int lat = 3;
  // Delay engine; a larger lat models slow channels
  always @(posedge sys_clk_in) begin
    if (delay_start_in === 1'b1) begin
      fork
        begin
          repeat (lat) @(posedge sys_clk_in);
          done_out <= 1'b1;
          @(posedge sys_clk_in) done_out <= 1'b0;
        end
      join_none
    end
  end
  // Mains period shortened to keep the run short
  task automatic pulses(input bit line, input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk_in);
      if (line) line_out <= 1'b1;
      else ext_trig_out <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      line_out <= 1'b0;
      ext_trig_out <= 1'b0;
      repeat (gap) @(posedge sys_clk_in);
    end
  endtask
endmodule

// file: tb/tb_delay_trigger_front_end.sv
`timescale 1ns/1ns
module tb_delay_trigger_front_end;
  localparam int unsigned NUM_OUT = 2;
  logic sys_clk_in = 1'b0, rst_in = 1'b1;
  dtfe_pkg::dtfe_src_e trig_source_in = dtfe_pkg::DTFE_SRC_MANUAL;
  logic [47:0] rate_step_in = 48'h0;
  logic [31:0] guard_cycles_in = 32'h0;
  logic [29:0] trig_prescale_in = 30'h1;
  logic [31:0] out_prescale_in = 32'h0003_0002, out_phase_in = 32'h1;
  logic one_shot_cmd_in = 1'b0, advanced_enable_in = 1'b0;
  logic prescale_write_in = 1'b0, inhibit_in = 1'b0;
  logic settings_busy_in = 1'b0, burst_enable_in = 1'b0;
  logic ext_trig_in, line_in, delays_done_in, delay_start_out;
  logic reference_output, cycle_active_out, armed_ready_out;
  logic overrun_out, blocked_trigger_flag, burst_active_out;
  logic [NUM_OUT-1:0] out_enable_out;
  logic [NUM_OUT-1:0] q[$];
  int fail_count = 0, n_checks = 0, n_start = 0, n_ovr = 0, n_blk = 0, s;
  int m[2], p[2];
  always #5 sys_clk_in = ~sys_clk_in;
  dtfe_top #(.NUM_OUT(NUM_OUT)) dut (.sys_clk_in, .rst_in, .trig_source_in,
    .rate_step_in, .ext_trig_in, .line_in, .one_shot_cmd_in,
    .advanced_enable_in, .guard_cycles_in, .trig_prescale_in,
    .out_prescale_in, .out_phase_in, .prescale_write_in, .inhibit_in,
    .settings_busy_in, .burst_enable_in, .delays_done_in, .delay_start_out,
    .out_enable_out, .reference_output, .cycle_active_out, .armed_ready_out,
    .overrun_out, .blocked_trigger_flag, .burst_active_out);
  dtfe_partner pm (.sys_clk_in, .delay_start_in(delay_start_out),
    .ext_trig_out(ext_trig_in), .line_out(line_in),
    .done_out(delays_done_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic cmd();
    @(posedge sys_clk_in) one_shot_cmd_in <= 1'b1;
    @(posedge sys_clk_in) one_shot_cmd_in <= 1'b0;
  endtask
  task automatic cfg(input dtfe_pkg::dtfe_src_e sr, input logic a, int n);
    @(posedge sys_clk_in);
    trig_source_in <= sr;
    advanced_enable_in <= a;
    trig_prescale_in <= 30'(n);
    prescale_write_in <= 1'b1;
    @(posedge sys_clk_in) prescale_write_in <= 1'b0;
    cyc(4);
  endtask
  task automatic exp_all(input int k);
    repeat (k) q.push_back('1);
  endtask
  // An unexpected start pops nothing and fails against a bad mask
  always @(posedge sys_clk_in) begin
    if (overrun_out === 1'b1) n_ovr++;
    if (blocked_trigger_flag === 1'b1) n_blk++;
    if (delay_start_out === 1'b1) begin
      n_start++;
      if (q.size() == 0) chk(32'(out_enable_out), 32'hbad);
      else chk(32'(out_enable_out), 32'(q.pop_front()));
    end
  end
  // Whole sequence needs about 31 us
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h88b2));
    cyc(4);
    rst_in <= 1'b0;
    cfg(dtfe_pkg::DTFE_SRC_MANUAL, 1'b1, 5);
    exp_all(1);
    cmd();
    cyc(3);
    cmd();
    cyc(40);
    chk(reference_output, 0);
    settings_busy_in <= 1'b1;
    cmd();
    settings_busy_in <= 1'b0;
    inhibit_in <= 1'b1;
    cyc(4);
    cmd();
    inhibit_in <= 1'b0;
    cyc(10);
    chk(n_ovr, 1);
    chk(n_blk, 2);
    cfg(dtfe_pkg::DTFE_SRC_EXT_RISE, 1'b0, 5);
    exp_all(3);
    pm.pulses(0, 3, 40);
    cfg(dtfe_pkg::DTFE_SRC_EXT_FALL, 1'b0, 1);
    exp_all(2);
    pm.lat = 12;
    pm.pulses(0, 2, 40);
    pm.lat = 3;
    cfg(dtfe_pkg::DTFE_SRC_ARM_RISE, 1'b1, 3);
    pm.pulses(0, 1, 40);
    cmd();
    cyc(2);
    chk(armed_ready_out, 1);
    exp_all(1);
    pm.pulses(0, 2, 40);
    chk(armed_ready_out, 0);
    cfg(dtfe_pkg::DTFE_SRC_ARM_FALL, 1'b0, 1);
    cmd();
    exp_all(1);
    pm.pulses(0, 2, 40);
    chk(armed_ready_out, 0);
    for (int i = 0; i < 2; i++) begin
      m[i] = $urandom_range(3, 1);
      p[i] = $urandom_range(m[i] - 1, 0);
      out_prescale_in[16*i+:16] <= 16'(m[i]);
      out_phase_in[16*i+:16] <= 16'(p[i]);
    end
    cfg(dtfe_pkg::DTFE_SRC_EXT_RISE, 1'b1, 2);
    for (int k = 0; k < 4; k++) begin
      q.push_back({k % m[1] == p[1], k % m[0] == p[0]});
    end
    pm.pulses(0, 8, 40);
    out_prescale_in <= 32'h0001_0001;
    out_phase_in <= 32'h0;
    guard_cycles_in <= 32'h96;
    cfg(dtfe_pkg::DTFE_SRC_EXT_RISE, 1'b1, 1);
    exp_all(2);
    pm.pulses(0, 2, 40);
    cyc(150);
    pm.pulses(0, 1, 40);
    chk(n_ovr, 2);
    rate_step_in <= 48'h0200_0000_0000;
    exp_all(40);
    s = n_start;
    cfg(dtfe_pkg::DTFE_SRC_INT, 1'b0, 1);
    cyc(1024);
    chk((n_start - s) inside {[7:9]}, 1);
    s = n_start;
    rate_step_in <= 48'h0400_0000_0000;
    cyc(640);
    chk((n_start - s) inside {[9:11]}, 1);
    cfg(dtfe_pkg::DTFE_SRC_LINE, 1'b0, 1);
    cyc(30);
    q.delete();
    exp_all(3);
    pm.pulses(1, 3, 40);
    burst_enable_in <= 1'b1;
    cyc(3);
    chk(burst_active_out, 1);
    burst_enable_in <= 1'b0;
    cyc(3);
    chk(burst_active_out, 0);
    chk(q.size(), 0);
    stop_test();
  end
endmodule
bind dtfe_top dtfe_chk #(.NUM_OUT(NUM_OUT)) u_chk (.sys_clk_in, .rst_in,
  .trig_source_in, .one_shot_cmd_in, .advanced_enable_in, .inhibit_in,
  .settings_busy_in, .burst_enable_in, .delays_done_in, .delay_start_out,
  .out_enable_out, .reference_output, .cycle_active_out, .armed_ready_out,
  .overrun_out, .blocked_trigger_flag, .burst_active_out);
